// [src/osc_regs.svh]
/*
 * Constants of the oscillator clock gating block: clock rates, derived
 * half-period counts and reset values.
 * Assumes a single system clock of known rate drives every flip-flop.
 */
`ifndef OSC_REGS_SVH
`define OSC_REGS_SVH

// ****************************************************************
// Clock rates
// ****************************************************************
`define OSC_SYS_CLK_HZ 40000000
`define OSC_RC_FREQ_HZ 64000
`define OSC_XTAL_FREQ_HZ 32768

// ****************************************************************
// Half-period counts, rounded down to whole system cycles
// ****************************************************************
`define OSC_CNT_W 10
`define OSC_RC_HALF_CYC (`OSC_SYS_CLK_HZ / (2 * `OSC_RC_FREQ_HZ))
`define OSC_XTAL_HALF_CYC (`OSC_SYS_CLK_HZ / (2 * `OSC_XTAL_FREQ_HZ))

// ****************************************************************
// Reset values
// ****************************************************************
`define OSC_RCDIS_RST 1'b0
`define OSC_KEEP_RST 1'b0
`define OSC_LEVEL_RST 1'b0

`endif

// [src/osc_pkg.sv]
/*
 * Types shared by the oscillator clock gating design.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package osc_pkg;

	// Power state of the clock block, one-hot
	typedef enum logic [1:0] {
		OSC_ST_RUN = 2'b01,
		OSC_ST_STOP = 2'b10
	} osc_state_t;

endpackage

`default_nettype wire

// [src/osc_gen_if.sv]
/*
 * Link between the gating control and one clock generator.
 * Assumes both ends sit on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface osc_gen_if;
	logic run;
	logic level;

	modport ctrl (output run, input level);
	modport gen (input run, output level);
endinterface

`default_nettype wire

// [src/osc_tick_gen.sv]
/*
 * Square-wave generator: toggles its level every HALF system cycles while
 * run is high, and parks low with the counter cleared while run is low.
 * Assumes run comes from logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "osc_regs.svh"

module osc_tick_gen
	import osc_pkg::*;
#(
	parameter logic [`OSC_CNT_W-1:0] HALF = `OSC_CNT_W'(`OSC_RC_HALF_CYC)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	osc_gen_if.gen gi
);

	logic [`OSC_CNT_W-1:0] cnt;
	logic level;
	wire logic at_end = (cnt == HALF - `OSC_CNT_W'(1));

	assign gi.level = level;

	// ****************************************************************
	// Counter and level
	// ****************************************************************
	// A stopped clock rests low so consumers see a clean restart edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !gi.run) begin
			cnt <= '0;
			level <= `OSC_LEVEL_RST;
		end else if (at_end) begin
			cnt <= '0;
			level <= ~level;
		end else begin
			cnt <= cnt + `OSC_CNT_W'(1);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_GEN_HALF_PERIOD: assert property (@(posedge sys_clk) disable iff (sys_rst)
		($changed(level) && $past(gi.run)) |-> $past(cnt) == HALF - `OSC_CNT_W'(1))
		else $error("generator toggled off its half-period count");

	AST_GEN_PARKED: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!gi.run |=> !level && cnt == '0)
		else $error("stopped generator did not park low");

endmodule

`default_nettype wire

// [src/osc_clock_gating.sv]
/*
 * Oscillator clock gating: produces the RC clock and the crystal clock as
 * registered square waves and gates them by stop state, the crystal enable
 * and the two stop configuration bits.
 * Assumes the system integration unit, the configuration register and the
 * mode indications all sit on sys_clk; clocks out are levels for consumers
 * that sample them on sys_clk.
 */
// Functional notes
// - The RC clock runs from reset on and never pauses in run or wait.
// - The RC clock is a free-running square wave of nominally 64 kHz with no outside parts.
// - With the RC-disable bit set at stop entry the RC clock halts for the whole stop.
// - The RC-disable bit resets to zero so by default the RC clock runs in stop.
// - The crystal clock runs only while the integration unit drives its enable high.
// - Entering stop with the crystal-keep bit clear gates off the crystal clock and its PLL copy; the enable input is left alone.
// - With the crystal-keep bit set at stop entry the crystal clock runs through stop.
// - A crystal clock kept in stop lets the real-time clock count and wake the processor.
// - Wait mode changes none of the three clocks.
// - Entering break keeps all three clocks running without a gap.
// - The PLL reference clock is a buffered copy of the crystal clock for the clock generator.
// - The watchdog is clocked from the RC clock only, never from the crystal.
// - The RC clock goes out to both the integration unit and the watchdog.
// - The crystal clock goes out to clock generator, real-time clock, converter, display and others.
`timescale 1ns/1ps
`default_nettype none
`include "osc_regs.svh"

module osc_clock_gating
	import osc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic crystal_osc_enable,
	input wire logic stop_rc_disable,
	input wire logic stop_crystal_keep,
	input wire logic stop_enter,
	input wire logic stop_exit,
	input wire logic wait_mode,
	input wire logic break_state,
	output logic rc_clock_siu,
	output logic rc_clock_watchdog,
	output logic crystal_clock_cgen,
	output logic crystal_clock_rtc,
	output logic crystal_clock_adc,
	output logic crystal_clock_display,
	output logic crystal_clock_misc,
	output logic pll_reference_clock,
	output logic rtc_wake_ok,
	output logic in_stop
);

	localparam int RC_BOUND = 320;

	osc_state_t state;
	osc_state_t next_state;
	logic rcdis_l;
	logic keep_l;

	osc_gen_if rc_if ();
	osc_gen_if xt_if ();

	// ****************************************************************
	// Stop state sequencing
	// ****************************************************************
	// Entry during stop and exit during run are ignored
	wire logic is_stop = (state == OSC_ST_STOP);
	wire logic take_entry = !is_stop && stop_enter;
	wire logic take_exit = is_stop && stop_exit;

	always_comb begin
		next_state = state;
		case (state)
			OSC_ST_RUN: begin
				if (stop_enter) begin
					next_state = OSC_ST_STOP;
				end
			end
			OSC_ST_STOP: begin
				if (stop_exit) begin
					next_state = OSC_ST_RUN;
				end
			end
			default: begin
				next_state = OSC_ST_RUN;
			end
		endcase
	end

	// State and the configuration bits caught at stop entry
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= OSC_ST_RUN;
			rcdis_l <= `OSC_RCDIS_RST;
			keep_l <= `OSC_KEEP_RST;
		end else begin
			state <= next_state;
			if (take_entry) begin
				rcdis_l <= stop_rc_disable;
				keep_l <= stop_crystal_keep;
			end
		end
	end

	// ****************************************************************
	// Gating
	// ****************************************************************
	// Wait and break never reach these terms, so they leave clocks alone
	wire logic xtal_gate = !is_stop || keep_l;
	wire logic rc_run = !(is_stop && rcdis_l);
	wire logic xtal_run = crystal_osc_enable && xtal_gate;

	assign rc_if.run = rc_run;
	assign xt_if.run = xtal_run;

	osc_tick_gen #(
		.HALF(`OSC_CNT_W'(`OSC_RC_HALF_CYC))
	) u_rc_gen (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.gi(rc_if.gen)
	);

	osc_tick_gen #(
		.HALF(`OSC_CNT_W'(`OSC_XTAL_HALF_CYC))
	) u_xtal_gen (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.gi(xt_if.gen)
	);

	// ****************************************************************
	// Output registers
	// ****************************************************************
	// One flop stage per output keeps every consumer edge-aligned
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rc_clock_siu <= `OSC_LEVEL_RST;
			rc_clock_watchdog <= `OSC_LEVEL_RST;
			crystal_clock_cgen <= `OSC_LEVEL_RST;
			crystal_clock_rtc <= `OSC_LEVEL_RST;
			crystal_clock_adc <= `OSC_LEVEL_RST;
			crystal_clock_display <= `OSC_LEVEL_RST;
			crystal_clock_misc <= `OSC_LEVEL_RST;
			pll_reference_clock <= `OSC_LEVEL_RST;
			rtc_wake_ok <= 1'b0;
			in_stop <= 1'b0;
		end else begin
			rc_clock_siu <= rc_if.level;
			rc_clock_watchdog <= rc_if.level;
			crystal_clock_cgen <= xt_if.level;
			crystal_clock_rtc <= xt_if.level;
			crystal_clock_adc <= xt_if.level;
			crystal_clock_display <= xt_if.level;
			crystal_clock_misc <= xt_if.level;
			pll_reference_clock <= xt_if.level;
			rtc_wake_ok <= is_stop && xtal_run;
			in_stop <= is_stop;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_rc_entry;
		take_entry && stop_rc_disable;
	endsequence

	sequence s_rc_parked;
		##3 !rc_clock_watchdog;
	endsequence

	AST_RC_ALIVE: assert property (@(posedge sys_clk) disable iff (sys_rst || is_stop)
		1'b1 |-> ##[1:RC_BOUND] $changed(rc_clock_watchdog))
		else $error("rc clock stalled outside stop");

	// A restart needs a whole half period, so even a quick exit leaves the output low here
	AST_STOP_RC_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_rc_entry |-> s_rc_parked)
		else $error("rc clock not halted in stop with disable set");

	// Parked for the whole stop, not only at entry, so a late restart is caught
	AST_STOP_RC_HELD: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(is_stop && rcdis_l && $past(is_stop) && $past(is_stop, 2)) |-> !rc_clock_watchdog)
		else $error("rc clock restarted during stop with disable set");

	AST_RC_RESET_DEFAULT: assert property (@(posedge sys_clk)
		$past(sys_rst) |-> !rcdis_l && state == OSC_ST_RUN)
		else $error("rc disable not clear after reset");

	AST_XTAL_FOLLOWS_EN: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!crystal_osc_enable |=> ##1 !crystal_clock_cgen)
		else $error("crystal clock ran without enable");

	AST_STOP_XTAL_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(is_stop && !keep_l && !stop_exit) |=> ##1 (!pll_reference_clock && !crystal_clock_rtc))
		else $error("crystal clock ran in stop without keep");

	AST_KEEP_XTAL: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(is_stop && keep_l && crystal_osc_enable) |=> rtc_wake_ok)
		else $error("kept crystal clock not running in stop");

	AST_WAIT_NO_EFFECT: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(wait_mode && !is_stop) |-> (rc_run && xtal_run == crystal_osc_enable))
		else $error("wait mode altered a clock");

	AST_BREAK_KEEPS: assert property (@(posedge sys_clk) disable iff (sys_rst)
		($rose(break_state) && !is_stop && !stop_enter) |=> (rc_run && !is_stop))
		else $error("break entry disturbed clocks");

	AST_PLL_COPY: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pll_reference_clock == crystal_clock_cgen && crystal_clock_adc == crystal_clock_cgen)
		else $error("pll reference differs from crystal clock");

	AST_WDOG_RC: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$changed(rc_clock_watchdog) |-> $changed(rc_clock_siu))
		else $error("watchdog clock not from rc clock");

	AST_EXIT_RESUME: assert property (@(posedge sys_clk) disable iff (sys_rst)
		take_exit |=> (!is_stop && xtal_run == crystal_osc_enable && rc_run))
		else $error("stop exit did not restore clocks");

endmodule

`default_nettype wire

// [testbench/osc_siu_model.sv]
/*
 * Model of the integration unit: drives crystal enable, stop pulses
 * and the two stop configuration bits.
 * Assumes the block samples these on the rising edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module osc_siu_model (
	input wire logic sys_clk,
	output logic crystal_osc_enable,
	output logic stop_enter,
	output logic stop_exit,
	output logic stop_rc_disable,
	output logic stop_crystal_keep
);
	initial begin
		crystal_osc_enable = 1'b1;
		stop_enter = 1'b0;
		stop_exit = 1'b0;
		stop_rc_disable = 1'b0;
		stop_crystal_keep = 1'b0;
	end

	// Enable is a level owned by this unit
	task set_enable(input logic v);
		@(posedge sys_clk);
		#1 crystal_osc_enable = v;
	endtask

	// Bits settle a cycle before the stop pulse, then flip to prove latching
	task enter_stop(input logic rcdis, input logic keep);
		@(posedge sys_clk);
		#1 stop_rc_disable = rcdis;
		stop_crystal_keep = keep;
		@(posedge sys_clk);
		#1 stop_enter = 1'b1;
		@(posedge sys_clk);
		#1 stop_enter = 1'b0;
		stop_rc_disable = ~rcdis;
		stop_crystal_keep = ~keep;
	endtask

	task leave_stop;
		@(posedge sys_clk);
		#1 stop_exit = 1'b1;
		@(posedge sys_clk);
		#1 stop_exit = 1'b0;
	endtask
endmodule

`default_nettype wire

// [testbench/testbench.sv]
/*
 * Self-checking bench of the oscillator clock gating block.
 * Assumes the integration unit model drives the enable, stop and configuration inputs; the bench drives wait and break itself.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic sys_clk, sys_rst, wait_mode, break_state;
	logic en, s_in, s_out, rcd, keep;
	logic rc, rc_wd, xc, x_rtc, x_adc, x_dsp, x_misc, pll, wake, in_stop;
	int miscompares = 0;
	int n_compared = 0;

	osc_clock_gating dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .crystal_osc_enable(en),
		.stop_rc_disable(rcd), .stop_crystal_keep(keep), .stop_enter(s_in), .stop_exit(s_out),
		.wait_mode(wait_mode), .break_state(break_state), .rc_clock_siu(rc), .rc_clock_watchdog(rc_wd),
		.crystal_clock_cgen(xc), .crystal_clock_rtc(x_rtc), .crystal_clock_adc(x_adc),
		.crystal_clock_display(x_dsp), .crystal_clock_misc(x_misc), .pll_reference_clock(pll),
		.rtc_wake_ok(wake), .in_stop(in_stop));
	osc_siu_model siu (.sys_clk(sys_clk), .crystal_osc_enable(en), .stop_enter(s_in),
		.stop_exit(s_out), .stop_rc_disable(rcd), .stop_crystal_keep(keep));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task give_verdict;
		if (miscompares == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function logic sig(input int s);
		return s ? xc : rc;
	endfunction

	// Bounded wait for a level; running out ends the run
	task wait_lvl(input int s, input logic lvl, output int n);
		n = 0;
		while (sig(s) !== lvl && n < 2000) begin
			@(posedge sys_clk);
			#1 n++;
		end
		if (n >= 2000) begin
			chk(16'h0001, 16'h0000);
			give_verdict();
		end
	endtask

	// Sync to a low phase first, so that a clock caught high is not measured short
	task half(input int s, input int exp);
		int n;
		wait_lvl(s, 1'b0, n);
		wait_lvl(s, 1'b1, n);
		wait_lvl(s, 1'b0, n);
		chk(n[15:0], exp[15:0]);
	endtask

	task quiet(input int s);
		int bad;
		bad = 0;
		repeat (700) begin
			@(posedge sys_clk);
			#1 if (sig(s) !== 1'b0) bad++;
		end
		chk(bad[15:0], 16'h0000);
	endtask

	// ****************************************************************
	// Copies must track their source on every cycle
	// ****************************************************************
	always @(negedge sys_clk) begin
		if (!sys_rst) begin
			chk({15'h0000, rc_wd}, {15'h0000, rc});
			chk({11'h000, x_rtc, x_adc, x_dsp, x_misc, pll}, {11'h000, {5{xc}}});
		end
	end

	task t_run;
		half(0, 312);
		half(1, 610);
	endtask

	task t_wait_break;
		wait_mode = 1'b1;
		half(0, 312);
		half(1, 610);
		wait_mode = 1'b0;
		break_state = 1'b1;
		half(0, 312);
		half(1, 610);
		break_state = 1'b0;
	endtask

	task t_stop_off;
		siu.enter_stop(1'b1, 1'b0);
		repeat (2) @(posedge sys_clk);
		#1 chk({14'h0000, in_stop, wake}, 16'h0002);
		quiet(0);
		quiet(1);
		siu.leave_stop();
		half(0, 312);
		half(1, 610);
		chk({15'h0000, in_stop}, 16'h0000);
	endtask

	task t_stop_keep;
		siu.enter_stop(1'b0, 1'b1);
		repeat (2) @(posedge sys_clk);
		#1 chk({14'h0000, in_stop, wake}, 16'h0003);
		half(0, 312);
		half(1, 610);
		siu.leave_stop();
	endtask

	task t_enable;
		siu.set_enable(1'b0);
		repeat (3) @(posedge sys_clk);
		quiet(1);
		half(0, 312);
		siu.set_enable(1'b1);
		half(1, 610);
	endtask

	initial begin
		sys_rst = 1'b1;
		wait_mode = 1'b0;
		break_state = 1'b0;
		repeat (10) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		t_run();
		t_wait_break();
		t_stop_off();
		t_stop_keep();
		t_enable();
		give_verdict();
	end
endmodule

`default_nettype wire
